// File: mrb_regs.vh
`ifndef MRB_REGS_VH
`define MRB_REGS_VH
// Base mode register fields
`define MRB_MR_WIDTH      19
`define MRB_BL_LSB        0
`define MRB_BL_MSB        1
`define MRB_BT_BIT        3
`define MRB_DLLRST_BIT    8
`define MRB_BSEL_BIT      12
`define MRB_RESERVED_MASK 19'h4e080
`define MRB_MR_RESET      19'h00000
// Burst length encodings
`define MRB_BL_FIXED8     2'h0
`define MRB_BL_OTF        2'h1
`define MRB_BL_CHOP4      2'h2
// Burst type encoding
`define MRB_BT_SEQ        1'h0
`define MRB_BT_INTLV      1'h1
// Command encodings {cs_n, ras_n, cas_n, we_n}
`define MRB_CMD_MRS       4'h0
`define MRB_CMD_READ      4'h5
`define MRB_CMD_WRITE     4'h4
`define MRB_BA_MR0        3'h0
// Timing counts in link clock cycles
`define MRB_REGISTER_WRITE_SPACING_CK       4'h4
`define MRB_MODE_UPDATE_DELAY_CK       4'hc
`define MRB_LOOP_LOCK_TIME_CK      10'h200
`define MRB_BEATS         4'h8
`define MRB_CHOP_BEATS    4'h4
`endif

// File: mrb_fifo.v
`timescale 1ns/1ns
module mrb_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output reg  [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_reg;
    reg [AW:0]      rd_reg;
    wire            full;
    wire            empty;
    assign full      = (wr_reg[AW-1:0] == rd_reg[AW-1:0]) && (wr_reg[AW] != rd_reg[AW]);
    assign empty     = (wr_reg == rd_reg);
    assign in_ready  = !full;
    assign out_valid = !empty;
    always @* begin
        out_data = mem[rd_reg[AW-1:0]];
    end
    always @(posedge clk) begin
        if (in_valid && !full) begin
            mem[wr_reg[AW-1:0]] <= in_data;
        end
    end
    always @(posedge clk) begin
        if (rst) begin
            wr_reg <= {(AW+1){1'b0}};
            rd_reg <= {(AW+1){1'b0}};
        end else begin
            if (in_valid && !full) begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (out_ready && !empty) begin
                rd_reg <= rd_reg + 1'b1;
            end
        end
    end
endmodule

// File: mrb_core.v
`timescale 1ns/1ns
`include "mrb_regs.vh"
module mrb_core #(
    parameter DW   = 8,
    parameter COLW = 10
) (
    input  wire            clk,
    input  wire            rst,
    input  wire            ck_pin,
    input  wire            reset_n_pin,
    input  wire            cmd_cs_n,
    input  wire            cmd_ras_n,
    input  wire            cmd_cas_n,
    input  wire            cmd_we_n,
    input  wire [2:0]      cmd_ba,
    input  wire [18:0]     cmd_addr,
    input  wire [DW-1:0]   wr_data,
    input  wire [DW-1:0]   rd_in_data,
    input  wire            rd_in_valid,
    output wire            rd_in_ready,
    output reg  [COLW-1:0] col_addr,
    output reg             col_valid,
    output reg             col_is_write,
    output reg  [DW-1:0]   wr_out_data,
    output reg  [DW-1:0]   dq_out,
    output reg             dq_oe,
    output reg             dqs_oe,
    output reg  [18:0]     mode_value,
    output reg             features_ready,
    output reg             dll_reset_pulse,
    output reg             dll_locked
);
    localparam ST_IDLE  = 3'h1;
    localparam ST_READ  = 3'h2;
    localparam ST_WRITE = 3'h4;

    reg        ck_s1_reg, ck_s2_reg, ck_s3_reg;
    reg        rn_s1_reg, rn_s2_reg;
    reg [3:0]  cmd_s1_reg, cmd_s2_reg;
    reg [2:0]  ba_s1_reg, ba_s2_reg;
    reg [18:0] ad_s1_reg, ad_s2_reg;
    reg [DW-1:0] wd_s1_reg, wd_s2_reg;
    reg [18:0] mr_reg;
    reg [3:0]  mod_cnt_reg;
    reg [9:0]  lock_cnt_reg;
    reg [2:0]  state_reg;
    reg [3:0]  beat_reg;
    reg [2:0]  start_reg;
    reg        chop_reg;
    reg        intlv_reg;
    reg [COLW-1:0] base_reg;
    wire       ck_rise;
    wire       live;
    wire [3:0] cmd;
    wire       chop_now;
    wire [2:0] order;

    // Beat index to column low bits
    function [2:0] mrb_order;
        input [2:0] start;
        input [2:0] beat;
        input       intlv;
        begin
            if (intlv == `MRB_BT_INTLV)
                mrb_order = start ^ beat;
            else
                mrb_order = {start[2] ^ beat[2], start[1:0] + beat[1:0]};
        end
    endfunction

    always @(posedge clk) begin
        ck_s1_reg  <= ck_pin;
        ck_s2_reg  <= ck_s1_reg;
        ck_s3_reg  <= ck_s2_reg;
        rn_s1_reg  <= reset_n_pin;
        rn_s2_reg  <= rn_s1_reg;
        cmd_s1_reg <= {cmd_cs_n, cmd_ras_n, cmd_cas_n, cmd_we_n};
        cmd_s2_reg <= cmd_s1_reg;
        ba_s1_reg  <= cmd_ba;
        ba_s2_reg  <= ba_s1_reg;
        ad_s1_reg  <= cmd_addr;
        ad_s2_reg  <= ad_s1_reg;
        wd_s1_reg  <= wr_data;
        wd_s2_reg  <= wd_s1_reg;
    end

    // Pins sampled on the rising link clock edge; slow link keeps them stable
    assign ck_rise  = ck_s2_reg && !ck_s3_reg;
    assign live     = !rst && rn_s2_reg;
    assign cmd      = cmd_s2_reg;
    assign chop_now = (mr_reg[`MRB_BL_MSB:`MRB_BL_LSB] == `MRB_BL_CHOP4) ||
                      ((mr_reg[`MRB_BL_MSB:`MRB_BL_LSB] == `MRB_BL_OTF) &&
                       !ad_s2_reg[`MRB_BSEL_BIT]);
    assign order    = mrb_order(start_reg, beat_reg[2:0], intlv_reg);
    assign rd_in_ready = (state_reg == ST_READ) && ck_rise;

    always @(posedge clk) begin
        if (!live) begin
            mr_reg          <= `MRB_MR_RESET;
            mode_value      <= `MRB_MR_RESET;
            mod_cnt_reg     <= 4'h0;
            lock_cnt_reg    <= 10'h0;
            features_ready  <= 1'b1;
            dll_reset_pulse <= 1'b0;
            dll_locked      <= 1'b0;
            state_reg       <= ST_IDLE;
            beat_reg        <= 4'h0;
            start_reg       <= 3'h0;
            chop_reg        <= 1'b0;
            intlv_reg       <= 1'b0;
            base_reg        <= {COLW{1'b0}};
            col_addr        <= {COLW{1'b0}};
            col_valid       <= 1'b0;
            col_is_write    <= 1'b0;
            wr_out_data     <= {DW{1'b0}};
            dq_out          <= {DW{1'b0}};
            dq_oe           <= 1'b0;
            dqs_oe          <= 1'b0;
        end else begin
            dll_reset_pulse <= 1'b0;
            col_valid       <= 1'b0;
            if (ck_rise) begin
                if (mod_cnt_reg != 4'h0) begin
                    mod_cnt_reg <= mod_cnt_reg - 4'h1;
                end else begin
                    features_ready <= 1'b1;
                end
                if (lock_cnt_reg != 10'h0) begin
                    lock_cnt_reg <= lock_cnt_reg - 10'h1;
                end else begin
                    dll_locked <= 1'b1;
                end
                if (cmd == `MRB_CMD_MRS && ba_s2_reg == `MRB_BA_MR0) begin
                    mr_reg <= ad_s2_reg & ~(19'h1 << `MRB_DLLRST_BIT);
                    mode_value <= ad_s2_reg & ~(19'h1 << `MRB_DLLRST_BIT);
                    features_ready <= 1'b0;
                    mod_cnt_reg <= `MRB_MODE_UPDATE_DELAY_CK;
                    if (ad_s2_reg[`MRB_DLLRST_BIT]) begin
                        dll_reset_pulse <= 1'b1;
                        dll_locked      <= 1'b0;
                        lock_cnt_reg    <= `MRB_LOOP_LOCK_TIME_CK;
                    end
                end
                case (state_reg)
                    ST_IDLE: begin
                        dq_oe  <= 1'b0;
                        dqs_oe <= 1'b0;
                        if (cmd == `MRB_CMD_READ || cmd == `MRB_CMD_WRITE) begin
                            beat_reg  <= 4'h0;
                            chop_reg  <= chop_now;
                            intlv_reg <= mr_reg[`MRB_BT_BIT];
                            base_reg  <= {ad_s2_reg[COLW-1:3], 3'h0};
                            if (cmd == `MRB_CMD_WRITE) begin
                                start_reg <= chop_now ? {ad_s2_reg[2], 2'h0} : 3'h0;
                                state_reg <= ST_WRITE;
                            end else begin
                                start_reg <= ad_s2_reg[2:0];
                                state_reg <= ST_READ;
                            end
                        end
                    end
                    ST_READ: begin
                        if (chop_reg && beat_reg >= `MRB_CHOP_BEATS) begin
                            dq_oe  <= 1'b0;
                            dqs_oe <= 1'b0;
                        end else begin
                            dq_oe        <= 1'b1;
                            dqs_oe       <= 1'b1;
                            dq_out       <= rd_in_valid ? rd_in_data : {DW{1'b0}};
                            col_addr     <= base_reg | {{(COLW-3){1'b0}}, order};
                            col_valid    <= 1'b1;
                            col_is_write <= 1'b0;
                        end
                        beat_reg <= beat_reg + 4'h1;
                        if (beat_reg == `MRB_BEATS - 4'h1) begin
                            state_reg <= ST_IDLE;
                        end
                    end
                    ST_WRITE: begin
                        // Unused chop slots are dropped
                        if (!(chop_reg && beat_reg >= `MRB_CHOP_BEATS)) begin
                            col_addr     <= base_reg | {{(COLW-3){1'b0}}, start_reg + beat_reg[2:0]};
                            col_valid    <= 1'b1;
                            col_is_write <= 1'b1;
                            wr_out_data  <= wd_s2_reg;
                        end
                        beat_reg <= beat_reg + 4'h1;
                        if (beat_reg == `MRB_BEATS - 4'h1) begin
                            state_reg <= ST_IDLE;
                        end
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                    end
                endcase
            end
        end
    end
endmodule

// File: mrb_top.v
`timescale 1ns/1ns
module mrb_top #(
    parameter DW   = 8,
    parameter COLW = 10
) (
    input  wire            clk,
    input  wire            rst,
    input  wire            ck_pin,
    input  wire            reset_n_pin,
    input  wire            cmd_cs_n,
    input  wire            cmd_ras_n,
    input  wire            cmd_cas_n,
    input  wire            cmd_we_n,
    input  wire [2:0]      cmd_ba,
    input  wire [18:0]     cmd_addr,
    input  wire [DW-1:0]   wr_data,
    input  wire [DW-1:0]   array_data,
    input  wire            array_valid,
    output wire            array_ready,
    output wire [COLW-1:0] col_addr,
    output wire            col_valid,
    output wire            col_is_write,
    output wire [DW-1:0]   wr_out_data,
    output wire [DW-1:0]   dq_out,
    output wire            dq_oe,
    output wire            dqs_oe,
    output wire [18:0]     mode_value,
    output wire            features_ready,
    output wire            dll_reset_pulse,
    output wire            dll_locked
);
    wire [DW-1:0] f_data;
    wire          f_valid;
    wire          f_ready;
    // Read data is staged so the array may run ahead of the beats
    mrb_fifo #(.WIDTH(DW), .DEPTH(8), .AW(3)) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_data   (array_data),
        .in_valid  (array_valid),
        .in_ready  (array_ready),
        .out_data  (f_data),
        .out_valid (f_valid),
        .out_ready (f_ready)
    );
    mrb_core #(.DW(DW), .COLW(COLW)) u_core (
        .clk             (clk),
        .rst             (rst),
        .ck_pin          (ck_pin),
        .reset_n_pin     (reset_n_pin),
        .cmd_cs_n        (cmd_cs_n),
        .cmd_ras_n       (cmd_ras_n),
        .cmd_cas_n       (cmd_cas_n),
        .cmd_we_n        (cmd_we_n),
        .cmd_ba          (cmd_ba),
        .cmd_addr        (cmd_addr),
        .wr_data         (wr_data),
        .rd_in_data      (f_data),
        .rd_in_valid     (f_valid),
        .rd_in_ready     (f_ready),
        .col_addr        (col_addr),
        .col_valid       (col_valid),
        .col_is_write    (col_is_write),
        .wr_out_data     (wr_out_data),
        .dq_out          (dq_out),
        .dq_oe           (dq_oe),
        .dqs_oe          (dqs_oe),
        .mode_value      (mode_value),
        .features_ready  (features_ready),
        .dll_reset_pulse (dll_reset_pulse),
        .dll_locked      (dll_locked)
    );
endmodule

// File: mrb_chk_sva.sv
`timescale 1ns/1ns
module mrb_chk #(
    parameter COLW = 10
) (
    input wire            clk,
    input wire            rst,
    input wire            reset_n_pin,
    input wire            cmd_cs_n,
    input wire            cmd_ras_n,
    input wire            cmd_cas_n,
    input wire            cmd_we_n,
    input wire [2:0]      cmd_ba,
    input wire [COLW-1:0] col_addr,
    input wire            col_valid,
    input wire            col_is_write,
    input wire            dq_oe,
    input wire            dqs_oe,
    input wire [18:0]     mode_value,
    input wire            features_ready,
    input wire            dll_reset_pulse,
    input wire            dll_locked
);
    logic [12:0] low_cnt;
    logic [12:0] lock_cnt;
    wire         mrs_seen = ({cmd_cs_n, cmd_ras_n, cmd_cas_n, cmd_we_n} == 4'h0) && (cmd_ba == 3'h0);
    default clocking @(posedge clk); endclocking
    default disable iff (rst || !reset_n_pin);
    // Lock counter saturates so the lock seen after a plain reset passes
    always @(posedge clk) begin
        if (rst) begin
            low_cnt  <= 13'h0;
            lock_cnt <= 13'h1fff;
        end else begin
            low_cnt  <= features_ready ? 13'h0 : low_cnt + 13'h1;
            lock_cnt <= dll_reset_pulse ? 13'h0 : lock_cnt + {12'h0, ~&lock_cnt};
        end
    end
    chk_dll_self_clear: assert property (!mode_value[8])
        else $error("dll reset bit stored");
    chk_pulse_single: assert property (dll_reset_pulse |=> !dll_reset_pulse)
        else $error("dll reset pulse too long");
    chk_lock_time: assert property ($rose(dll_locked) |-> lock_cnt >= 13'h13ec)
        else $error("dll lock too early");
    chk_update_delay: assert property ($rose(features_ready) |->
        low_cnt >= 13'h6e && low_cnt <= 13'h82)
        else $error("update delay length off");
    chk_mode_hold: assert property ($changed(mode_value) |-> $past(mrs_seen))
        else $error("mode value changed without register write");
    chk_oe_pair: assert property (dq_oe == dqs_oe)
        else $error("data and strobe enables differ");
    chk_read_drives: assert property (col_valid && !col_is_write |-> ##[0:1] dq_oe)
        else $error("read beat not driven");
    chk_block_wrap: assert property (col_valid ##10 col_valid |->
        ((col_addr ^ $past(col_addr, 10)) >> 3) == {COLW{1'b0}})
        else $error("burst left its column block");
    chk_seq_order: assert property (col_valid ##10 col_valid && !mode_value[3] |->
        2'(col_addr - $past(col_addr, 10)) == 2'h1)
        else $error("sequential order broken");
    chk_intlv_order: assert property (col_valid ##10 col_valid && mode_value[3] |->
        1'(col_addr ^ $past(col_addr, 10)) == 1'h1)
        else $error("interleaved order broken");
    chk_write_start: assert property (col_valid && col_is_write && !$past(col_valid, 10) |->
        col_addr[1:0] == 2'h0)
        else $error("write burst start not aligned");
    cover property (col_valid && col_is_write);
    cover property (dll_reset_pulse);
    cover property ($rose(features_ready));
endmodule
bind mrb_top mrb_chk #(.COLW(COLW)) u_mrb_chk (
    .clk, .rst, .reset_n_pin, .cmd_cs_n, .cmd_ras_n, .cmd_cas_n, .cmd_we_n, .cmd_ba,
    .col_addr, .col_valid, .col_is_write, .dq_oe, .dqs_oe, .mode_value,
    .features_ready, .dll_reset_pulse, .dll_locked
);

// File: mrb_ctrl_model.sv
`timescale 1ns/1ns
module mrb_ctrl_model (
    input  wire         clk,
    output logic        ck_pin,
    output logic        cmd_cs_n,
    output logic        cmd_ras_n,
    output logic        cmd_cas_n,
    output logic        cmd_we_n,
    output logic [2:0]  cmd_ba,
    output logic [18:0] cmd_addr,
    output logic [7:0]  wr_data
);
    initial begin
        ck_pin = 1'b0;
        {cmd_cs_n, cmd_ras_n, cmd_cas_n, cmd_we_n} = 4'hf;
        cmd_ba = 3'h0;
        cmd_addr = 19'h0;
        wr_data = 8'h0;
    end
    // Free running, edges fall between clk rising edges
    always #40 ck_pin = ~ck_pin;
    // Pins change just after clk, half a link period before the sampling edge
    task automatic step(input logic [3:0] cmd, input logic [2:0] ba, input logic [18:0] adr);
        @(negedge ck_pin);
        @(posedge clk);
        {cmd_cs_n, cmd_ras_n, cmd_cas_n, cmd_we_n} <= cmd;
        cmd_ba <= ba;
        cmd_addr <= adr;
        wr_data <= wr_data + 8'h1;
    endtask
    // idle slots only; deselected lines show the inverse of the last value
    task automatic idle(input int n);
        repeat (n) step(4'hf, ~cmd_ba, ~cmd_addr);
    endtask
    task automatic mode_register_write_cmd(input logic [2:0] ba, input logic [18:0] val);
        step(`MRB_CMD_MRS, ba, val);
        idle(13);
    endtask
    // no register write while a burst is still running
    task automatic burst(input logic [3:0] cmd, input logic [18:0] col);
        step(cmd, 3'h0, col);
        idle(9);
    endtask
endmodule

// File: testbench.sv
`timescale 1ns/1ns
`include "mrb_regs.vh"
module testbench;
    logic        clk = 1'b0, rst = 1'b1, reset_n_pin = 1'b1, array_valid = 1'b0;
    logic [7:0]  array_data = 8'h0;
    wire         ck_pin, cmd_cs_n, cmd_ras_n, cmd_cas_n, cmd_we_n, array_ready;
    wire  [2:0]  cmd_ba;
    wire  [18:0] cmd_addr, mode_value;
    wire  [7:0]  wr_data, wr_out_data, dq_out;
    wire  [9:0]  col_addr;
    wire         col_valid, col_is_write, dq_oe, dqs_oe, features_ready, dll_reset_pulse;
    wire         dll_locked;
    logic [9:0]  got_col[$];
    logic [7:0]  got_dat[$];
    logic [7:0]  got_wd[$];
    logic [1:0]  cv_d = 2'h0;
    logic [1:0]  bl_tab[3] = '{2'h0, 2'h2, 2'h1};
    logic        armed = 1'b0, chop;
    logic [18:0] mv, col;
    time         cmd_t, lat, ref_lat = 0;
    int          error_cnt = 0, tests_run = 0, k;

    mrb_top u_mrb_top (.clk, .rst, .ck_pin, .reset_n_pin, .cmd_cs_n, .cmd_ras_n, .cmd_cas_n,
        .cmd_we_n, .cmd_ba, .cmd_addr, .wr_data, .array_data, .array_valid, .array_ready,
        .col_addr, .col_valid, .col_is_write, .wr_out_data, .dq_out, .dq_oe, .dqs_oe,
        .mode_value, .features_ready, .dll_reset_pulse, .dll_locked);
    mrb_ctrl_model u_mrb_ctrl_model (.clk, .ck_pin, .cmd_cs_n, .cmd_ras_n, .cmd_cas_n,
        .cmd_we_n, .cmd_ba, .cmd_addr, .wr_data);

    always #4 clk = ~clk;

    // Read data is taken two cycles after its beat, when it has surely settled
    always @(posedge clk) begin
        cv_d <= {cv_d[0], col_valid & ~col_is_write};
        if (col_valid === 1'b1) got_col.push_back(col_addr);
        if (col_valid === 1'b1 && col_is_write === 1'b1) got_wd.push_back(wr_out_data);
        if (cv_d[1] === 1'b1) got_dat.push_back(dq_out);
        if (!armed && {cmd_cs_n, cmd_ras_n, cmd_cas_n} === 3'h2) begin
            armed = 1'b1;
            cmd_t = $time;
        end
        if (armed && col_valid === 1'b1) begin
            lat = $time - cmd_t;
            armed = 1'b0;
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [9:0] exp_col(logic [9:0] c, logic [2:0] i, bit ch, bit il, bit wr);
        logic [2:0] s;
        s = wr ? {c[2] & ch, 2'h0} : c[2:0];
        return {c[9:3], il ? s ^ i : {s[2] ^ i[2], s[1:0] + i[1:0]}};
    endfunction

    task automatic burst(input logic [3:0] cmd, input logic [18:0] c, input bit ch, input bit il);
        got_col.delete();
        got_wd.delete();
        u_mrb_ctrl_model.burst(cmd, c);
        repeat (12) @(posedge clk);
        check("beat count", ch ? 4 : 8, got_col.size());
        for (int i = 0; i < (ch ? 4 : 8); i++) begin
            check("column", exp_col(c[9:0], i[2:0], ch, il, cmd == `MRB_CMD_WRITE), got_col[i]);
        end
        if (cmd == `MRB_CMD_WRITE) begin
            for (int i = 1; i < got_wd.size(); i++) begin
                check("write data", 8'(got_wd[0] + i), got_wd[i]);
            end
        end
        if (ref_lat == 0) ref_lat = lat;
        check("start delay", ref_lat, lat);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(posedge clk);
        check("mode after reset", 19'h0, mode_value);
        check("ready after reset", 1'b1, features_ready);
        $display("test reset done");
        u_mrb_ctrl_model.mode_register_write_cmd(3'h0, 19'h00100);
        check("dll bit cleared", 19'h0, mode_value);
        check("lock dropped", 1'b0, dll_locked);
        // no read before the loop has relocked
        for (k = 0; k < 6000 && dll_locked !== 1'b1; k++) @(posedge clk);
        if (dll_locked !== 1'b1) begin
            error_cnt++;
            complete_run();
        end
        $display("test dll reset done");
        k = 0;
        array_valid <= 1'b1;
        array_data <= 8'ha0;
        repeat (10) begin
            @(posedge clk);
            if (array_ready === 1'b1) k++;
            array_data <= 8'ha0 + k[7:0];
        end
        array_valid <= 1'b0;
        check("words taken", 8, k);
        got_dat.delete();
        burst(`MRB_CMD_READ, 19'h158, 1'b0, 1'b0);
        for (int i = 0; i < 8; i++) check("read data", 8'ha0 + i, got_dat[i]);
        check("buffer drained", 1'b1, array_ready);
        $display("test buffer done");
        for (int b = 0; b < 3; b++) begin
            for (int t = 0; t < 2; t++) begin
                mv = {15'h0, t[0], 1'b0, bl_tab[b]};
                u_mrb_ctrl_model.mode_register_write_cmd(3'h0, mv);
                check("mode value", mv, mode_value);
                check("update pending", 1'b0, features_ready);
                for (int a = 0; a < 2; a++) begin
                    col = {6'h0, a[0], 2'h0, 7'h2b, a[0] ? 3'h6 : 3'h1};
                    chop = (bl_tab[b] == 2'h2) || (bl_tab[b] == 2'h1 && a == 0);
                    burst(`MRB_CMD_READ, col, chop, t[0]);
                    burst(`MRB_CMD_WRITE, col, chop, t[0]);
                end
            end
        end
        $display("test burst orders done");
        u_mrb_ctrl_model.mode_register_write_cmd(3'h2, 19'h00002);
        check("other bank ignored", mv, mode_value);
        reset_n_pin <= 1'b0;
        repeat (6) @(posedge clk);
        reset_n_pin <= 1'b1;
        repeat (6) @(posedge clk);
        check("mode after pin reset", 19'h0, mode_value);
        $display("test hold and reset done");
        complete_run();
    end
endmodule
